// *** core/pdr_pkg.sv ***
// Constants and field layouts for the serially programmed divider latches.
// Assumes the user writes every reference as pdr_pkg::name, with no import.
package pdr_pkg;

   localparam int WORD_WIDTH  = 22;
   localparam int DATA_WIDTH  = 20;
   localparam int RATIO_WIDTH = 20;
   localparam int ADDR_LSB    = 0;
   localparam int ADDR_MSB    = 1;
   localparam int DATA_LSB    = 2;
   localparam int DATA_MSB    = 21;

   // Address values of the four latches.
   localparam logic [1:0] ADDR_AUX_REF  = 2'h0;
   localparam logic [1:0] ADDR_AUX_FB   = 2'h1;
   localparam logic [1:0] ADDR_MAIN_REF = 2'h2;
   localparam logic [1:0] ADDR_MAIN_FB  = 2'h3;

   // Prescaler moduli as left shifts: main loop 16 or 32, auxiliary loop 8 or 16.
   localparam int MAIN_LOW_SHIFT  = 4;
   localparam int MAIN_HIGH_SHIFT = 5;
   localparam int AUX_LOW_SHIFT   = 3;
   localparam int AUX_HIGH_SHIFT  = 4;

   localparam logic [WORD_WIDTH-1:0]  SHIFT_RESET = 22'h000000;
   localparam logic [DATA_WIDTH-1:0]  LATCH_RESET = 20'h00000;
   localparam logic [RATIO_WIDTH-1:0] COUNT_RESET = 20'h00000;

   typedef struct packed {
      logic [1:0]  lock_output_select;
      logic        main_pump_float;
      logic        main_pump_current_high;
      logic        main_detector_polarity;
      logic [14:0] main_ref_count;
   } pdr_ref_type;

   typedef struct packed {
      logic        power_off;
      logic        prescaler_high;
      logic [12:0] program_count;
      logic [4:0]  swallow_count;
   } pdr_fb_type;

endpackage

// *** core/pdr_div.sv ***
// Programmable divider: counts input ticks and pulses once per ratio ticks.
// Assumes i_tick is already in the i_clk domain and lasts one cycle.
`timescale 1ns/1ns
module pdr_div
(
   // Clock and reset
   input  wire logic                              i_clk,
   input  wire logic                              i_resetn,
   // Control
   input  wire logic                              i_hold,
   input  wire logic                              i_tick,
   input  wire logic [pdr_pkg::RATIO_WIDTH-1:0]   i_ratio,
   // Result
   output logic                                   o_pulse
);

   logic [pdr_pkg::RATIO_WIDTH-1:0] count_reg;
   logic [pdr_pkg::RATIO_WIDTH-1:0] count_next;
   logic                            pulse_next;
   logic [pdr_pkg::RATIO_WIDTH-1:0] count_inc;
   wire                             wrap;

   assign count_inc = count_reg + 20'h00001;
   // Comparing the incremented count avoids underflow of ratio minus one.
   assign wrap = (count_inc >= i_ratio);

   always_comb
   begin
      count_next = count_reg;
      pulse_next = 1'b0;
      if (i_hold)
      begin
         count_next = pdr_pkg::COUNT_RESET;
      end
      else if (i_tick)
      begin
         count_next = wrap ? pdr_pkg::COUNT_RESET : count_inc;
         pulse_next = wrap;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         count_reg <= pdr_pkg::COUNT_RESET;
         o_pulse   <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         o_pulse   <= pulse_next;
      end
   end

endmodule

// *** core/pdr_regs.sv ***
// Serial divider programming port with four latches and the loop dividers.
// Assumes the host holds the link clock still while the latch strobe is high,
// and keeps the strobe high for at least four system clock periods.
`timescale 1ns/1ns

// Functional notes
// RULE1: Address 10 copies the data bits into the main reference latch on strobe rise.
// RULE2: The 15-bit main reference field is the main reference divide ratio.
// RULE3: The host loads reference ratios from 2 to 32767; the divider uses the value as is.
// RULE4: Words shift in most significant bit first; 00 is auxiliary and 10 main reference.
// RULE5: Address 01 latches the auxiliary feedback word with count, prescaler and power-off.
// RULE6: Address 11 latches the main feedback word with count, prescaler and power-off.
// RULE7: Feedback data is swallow count low, program count above, then prescaler, power-off.
// RULE8: The host loads program counts from 3 to 8191.
// RULE9: The swallow count is plain binary 0 to 31, zero meaning no swallowed cycles.
// RULE10: The host keeps swallow below the modulus and program count above swallow.
// RULE11: Main reference top bits are lock select pair, pump float, pump current, polarity.
// RULE12: Prescaler select 0 picks the lower modulus and 1 the higher one.
// RULE13: Power-off holds a loop's counters at zero while loads keep being accepted.
// RULE14: A strobe updates only the latch selected by the address field.
module pdr_regs
(
   // System clock and reset
   input  wire logic                            i_clk,
   input  wire logic                            i_resetn,
   // Serial link
   input  wire logic                            i_link_clk,
   input  wire logic                            i_link_data,
   input  wire logic                            i_latch_strobe,
   // Divider inputs from the loops
   input  wire logic                            i_main_ref_in,
   input  wire logic                            i_main_vco_in,
   input  wire logic                            i_aux_vco_in,
   // Latched settings
   output pdr_pkg::pdr_ref_type                 o_main_ref,
   output pdr_pkg::pdr_fb_type                  o_main_fb,
   output pdr_pkg::pdr_fb_type                  o_aux_fb,
   output logic [pdr_pkg::DATA_WIDTH-1:0]       o_aux_ref_raw,
   // Divider outputs
   output logic                                 o_main_ref_pulse,
   output logic                                 o_main_fb_pulse,
   output logic                                 o_aux_fb_pulse
);

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain shift register.

   logic [pdr_pkg::WORD_WIDTH-1:0] shift_reg;

   // RULE4 most significant first
   always_ff @(posedge i_link_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         shift_reg <= pdr_pkg::SHIFT_RESET;
      else
         shift_reg <= {shift_reg[pdr_pkg::WORD_WIDTH-2:0], i_link_data};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for pins: strobe, reference and both VCO inputs.

   localparam int NSYNC = 4;
   wire  [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   logic [NSYNC-1:0] prev_reg;
   wire  [NSYNC-1:0] rise;

   assign pin_raw = {i_aux_vco_in, i_main_vco_in, i_main_ref_in, i_latch_strobe};

   generate
      for (genvar g = 0; g < NSYNC; g++)
      begin : g_sync
         always_ff @(posedge i_clk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               sync1_reg[g] <= 1'b0;
               sync2_reg[g] <= 1'b0;
               prev_reg[g]  <= 1'b0;
            end
            else
            begin
               sync1_reg[g] <= pin_raw[g];
               sync2_reg[g] <= sync1_reg[g];
               prev_reg[g]  <= sync2_reg[g];
            end
         end
         assign rise[g] = sync2_reg[g] & ~prev_reg[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Latch decode. The shift register is sampled only after the synchronised
   // strobe rises, by which time the stopped link clock has left it stable.

   wire                               load_now;
   wire [1:0]                         load_addr;
   wire [pdr_pkg::DATA_WIDTH-1:0]     load_data;

   function automatic logic hit(input logic [1:0] addr, input logic [1:0] sel);
      hit = (addr == sel);
   endfunction

   assign load_now  = rise[0];
   assign load_addr = shift_reg[pdr_pkg::ADDR_MSB:pdr_pkg::ADDR_LSB];
   assign load_data = shift_reg[pdr_pkg::DATA_MSB:pdr_pkg::DATA_LSB];

   wire load_aux_ref  = load_now & hit(load_addr, pdr_pkg::ADDR_AUX_REF);
   wire load_aux_fb   = load_now & hit(load_addr, pdr_pkg::ADDR_AUX_FB);
   wire load_main_ref = load_now & hit(load_addr, pdr_pkg::ADDR_MAIN_REF);
   wire load_main_fb  = load_now & hit(load_addr, pdr_pkg::ADDR_MAIN_FB);

   // RULE1 RULE5 RULE6 RULE14 selected latch only
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_aux_ref_raw <= pdr_pkg::LATCH_RESET;
         o_aux_fb      <= pdr_pkg::LATCH_RESET;
         o_main_ref    <= pdr_pkg::LATCH_RESET;
         o_main_fb     <= pdr_pkg::LATCH_RESET;
      end
      else
      begin
         if (load_aux_ref)
            o_aux_ref_raw <= load_data;
         // RULE7 RULE11 field layout
         if (load_aux_fb)
            o_aux_fb <= load_data;
         if (load_main_ref)
            o_main_ref <= load_data;
         if (load_main_fb)
            o_main_fb <= load_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Divide ratios: reference ratio taken as latched; feedback N = P * B + A, with P chosen by the prescaler select bit.

   wire [pdr_pkg::RATIO_WIDTH-1:0] main_ref_ratio;
   wire [pdr_pkg::RATIO_WIDTH-1:0] main_fb_ratio;
   wire [pdr_pkg::RATIO_WIDTH-1:0] aux_fb_ratio;
   wire [pdr_pkg::RATIO_WIDTH-1:0] main_b;
   wire [pdr_pkg::RATIO_WIDTH-1:0] aux_b;

   // RULE2 RULE3 ratio taken verbatim
   assign main_ref_ratio = {5'h00, o_main_ref.main_ref_count};
   assign main_b = {7'h00, o_main_fb.program_count};
   assign aux_b  = {7'h00, o_aux_fb.program_count};
   // RULE9 RULE12 swallow and modulus
   assign main_fb_ratio = (o_main_fb.prescaler_high ? (main_b << pdr_pkg::MAIN_HIGH_SHIFT)
                                                     : (main_b << pdr_pkg::MAIN_LOW_SHIFT))
                          + {15'h0000, o_main_fb.swallow_count};
   assign aux_fb_ratio  = (o_aux_fb.prescaler_high ? (aux_b << pdr_pkg::AUX_HIGH_SHIFT)
                                                   : (aux_b << pdr_pkg::AUX_LOW_SHIFT))
                          + {15'h0000, o_aux_fb.swallow_count};

   // RULE13 power-off holds counters
   pdr_div u_main_ref
   (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_hold   (o_main_fb.power_off),
      .i_tick   (rise[1]),
      .i_ratio  (main_ref_ratio),
      .o_pulse  (o_main_ref_pulse)
   );

   pdr_div u_main_fb
   (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_hold   (o_main_fb.power_off),
      .i_tick   (rise[2]),
      .i_ratio  (main_fb_ratio),
      .o_pulse  (o_main_fb_pulse)
   );

   pdr_div u_aux_fb
   (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_hold   (o_aux_fb.power_off),
      .i_tick   (rise[3]),
      .i_ratio  (aux_fb_ratio),
      .o_pulse  (o_aux_fb_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence load_seq(logic [1:0] sel);
      load_now && (load_addr == sel);
   endsequence

   main_ref_load_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE1
      load_seq(pdr_pkg::ADDR_MAIN_REF) |=> (o_main_ref == $past(load_data)))
      else $error("main reference latch missed its load");

   aux_fb_load_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE5
      load_seq(pdr_pkg::ADDR_AUX_FB) |=> (o_aux_fb == $past(load_data)))
      else $error("auxiliary feedback latch missed its load");

   main_fb_load_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE6
      load_seq(pdr_pkg::ADDR_MAIN_FB) |=> (o_main_fb == $past(load_data)))
      else $error("main feedback latch missed its load");

   other_latch_kept_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE14
      (load_now && (load_addr != pdr_pkg::ADDR_MAIN_REF)) |=> $stable(o_main_ref))
      else $error("main reference latch changed on another address");

   shift_msb_first_a : assert property (@(posedge i_link_clk) disable iff (!i_resetn) // RULE4
      1'b1 |=> (shift_reg[0] == $past(i_link_data))
               && (shift_reg[21:1] == $past(shift_reg[20:0])))
      else $error("serial word not shifted most significant bit first");

   swallow_field_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE7
      load_seq(pdr_pkg::ADDR_MAIN_FB) |=> (o_main_fb.swallow_count == $past(shift_reg[6:2]))
                                          && (o_main_fb.power_off == $past(shift_reg[21])))
      else $error("feedback fields misplaced");

   modulus_select_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE12
      main_fb_ratio == (o_main_fb.prescaler_high ? 20'h00020 : 20'h00010) * main_b
                       + {15'h0000, o_main_fb.swallow_count})
      else $error("main feedback ratio does not follow the modulus");

   power_off_hold_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE13
      o_main_fb.power_off [*2] |-> !o_main_ref_pulse && !o_main_fb_pulse)
      else $error("main counters ran while powered off");

   ref_ratio_a : assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE2
      load_seq(pdr_pkg::ADDR_MAIN_REF) |=> (main_ref_ratio[14:0] == $past(shift_reg[16:2])))
      else $error("reference ratio not taken from its field");

endmodule

// *** dv/pdr_host.sv ***
// Host side of the three-wire programming link: shifts words and strobes them in.
// Assumes i_clk is the block's system clock; it only paces the latch strobe.
`timescale 1ns/1ns
module pdr_host
(
   // Timing reference
   input  wire logic i_clk,
   // Serial link
   output logic      o_link_clk,
   output logic      o_link_data,
   output logic      o_latch_strobe
);
   initial
   begin
      o_link_clk     = 1'b0;
      o_link_data    = 1'b0;
      o_latch_strobe = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The link clock runs only inside a word, at 48 ns, and stands still otherwise.
   // most significant first
   task automatic send_word(input logic [21:0] w);
      for (int i = 21; i >= 0; i--)
      begin
         o_link_data = w[i];
         #24 o_link_clk = 1'b1;
         #24 o_link_clk = 1'b0;
      end
      // A released data line shows the inverse, so a stale bit never looks valid.
      o_link_data = ~w[0];
      repeat (2) @(negedge i_clk);
      o_latch_strobe = 1'b1;
      repeat (5) @(negedge i_clk);
      o_latch_strobe = 1'b0;
      repeat (5) @(negedge i_clk);
   endtask
endmodule

// *** dv/pdr_regs_tb.sv ***
// Self-checking bench for the divider programming latches and loop dividers.
// Assumes pdr_host drives the link; divider pins are driven here.
`timescale 1ns/1ns
module dual_pll_divider_program_regs_tb;
   logic                 i_clk = 1'b0;
   logic                 i_resetn = 1'b0;
   logic                 link_clk, link_data, latch_strobe;
   logic [2:0]           pins = 3'h0;
   logic [2:0]           pulses;
   pdr_pkg::pdr_ref_type main_ref;
   pdr_pkg::pdr_fb_type  main_fb, aux_fb;
   logic [19:0]          aux_ref;
   logic [19:0]          exp_val [4] = '{default: 20'h0};
   int                   pcnt [3];
   int                   n_mismatch = 0;
   int                   cmp_count = 0;

   pdr_regs u_pdr_regs (.i_clk(i_clk), .i_resetn(i_resetn), .i_link_clk(link_clk),
      .i_link_data(link_data), .i_latch_strobe(latch_strobe), .i_main_ref_in(pins[0]),
      .i_main_vco_in(pins[1]), .i_aux_vco_in(pins[2]), .o_main_ref(main_ref),
      .o_main_fb(main_fb), .o_aux_fb(aux_fb), .o_aux_ref_raw(aux_ref),
      .o_main_ref_pulse(pulses[0]), .o_main_fb_pulse(pulses[1]), .o_aux_fb_pulse(pulses[2]));
   pdr_host u_pdr_host (.i_clk(i_clk), .o_link_clk(link_clk), .o_link_data(link_data),
      .o_latch_strobe(latch_strobe));

   always #10 i_clk = ~i_clk;

   always @(posedge i_clk)
   begin
      for (int k = 0; k < 3; k++)
         if (pulses[k] === 1'b1)
            pcnt[k]++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic load(input logic [1:0] a, input logic [19:0] d);
      u_pdr_host.send_word({d, a});
      exp_val[a] = d;
   endtask

   task automatic check_all();
      chk(aux_ref, exp_val[0]);
      chk(aux_fb, exp_val[1]);
      chk(main_ref, exp_val[2]);
      chk(main_fb, exp_val[3]);
   endtask

   // Pins stay high 3 and low 3 cycles per edge; the tail lets the last pulse land.
   task automatic edges(input int k, input int n);
      pcnt = '{0, 0, 0};
      repeat (n)
      begin
         @(negedge i_clk);
         pins[k] = 1'b1;
         repeat (3) @(negedge i_clk);
         pins[k] = 1'b0;
         repeat (2) @(negedge i_clk);
      end
      repeat (8) @(negedge i_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_latch();
      logic [19:0] d [4];
      // Each feedback word keeps swallow below its modulus and B above swallow.
      d = '{20'h5A5A5, 20'hC3C2C, 20'h0F0F1, 20'hE1E1E};
      check_all();
      for (int a = 0; a < 4; a++)
      begin
         load(2'(a), d[a]);
         check_all();
      end
      load(2'h2, ~d[2]);
      check_all();
      $display("test latch done");
   endtask

   task automatic t_layout();
      load(2'h2, {2'h2, 1'b1, 1'b0, 1'b1, 15'h1234});
      chk(20'(main_ref.lock_output_select), 20'h2);
      chk(20'({main_ref.main_pump_float, main_ref.main_pump_current_high}), 20'h2);
      chk(20'(main_ref.main_detector_polarity), 20'h1);
      chk(20'(main_ref.main_ref_count), 20'h01234);
      load(2'h3, {1'b0, 1'b1, 13'h1ABC, 5'h15});
      chk(20'({main_fb.prescaler_high, main_fb.program_count}), 20'h03ABC);
      chk(20'(main_fb.swallow_count), 20'h15);
      $display("test layout done");
   endtask

   task automatic t_ref_div();
      // Ratio 3 kept in the host's legal span of 2 to 32767.
      load(2'h3, {1'b0, 1'b0, 13'h3, 5'h0});
      load(2'h2, 20'h3);
      edges(0, 7);
      chk(20'(pcnt[0]), 20'h2);
      $display("test ref divider done");
   endtask

   task automatic t_fb_div();
      int b;
      int a;
      int p;
      int k;
      for (int i = 0; i < 4; i++)
      begin
         k = (i < 2) ? 1 : 2;
         // Swallow stays below the modulus and B above swallow.
         p = (i < 2) ? (16 << i) : (8 << (i - 2));
         b = i[0] ? p : 3;
         a = i[0] ? p - 1 : ((i < 2) ? 0 : 2);
         load((i < 2) ? 2'h3 : 2'h1, {1'b0, i[0], 13'(b), 5'(a)});
         edges(k, p * b + a - 1);
         chk(20'(pcnt[k]), 20'h0);
         edges(k, 1);
         chk(20'(pcnt[k]), 20'h1);
      end
      $display("test feedback divider done");
   endtask

   task automatic t_power();
      load(2'h3, {1'b0, 1'b0, 13'h3, 5'h0});
      edges(1, 10);
      edges(0, 1);
      load(2'h3, {1'b1, 1'b0, 13'h3, 5'h0});
      chk(20'(main_fb.power_off), 20'h1);
      edges(1, 60);
      chk(20'(pcnt[1]), 20'h0);
      edges(0, 9);
      chk(20'(pcnt[0]), 20'h0);
      load(2'h3, {1'b0, 1'b0, 13'h3, 5'h0});
      edges(1, 47);
      chk(20'(pcnt[1]), 20'h0);
      edges(1, 1);
      chk(20'(pcnt[1]), 20'h1);
      edges(0, 2);
      chk(20'(pcnt[0]), 20'h0);
      edges(0, 1);
      chk(20'(pcnt[0]), 20'h1);
      // Auxiliary loop: a part-way count must be cleared by power-off.
      edges(2, 5);
      load(2'h1, {1'b1, 1'b0, 13'h3, 5'h0});
      edges(2, 30);
      chk(20'(pcnt[2]), 20'h0);
      load(2'h1, {1'b0, 1'b0, 13'h3, 5'h0});
      edges(2, 23);
      chk(20'(pcnt[2]), 20'h0);
      edges(2, 1);
      chk(20'(pcnt[2]), 20'h1);
      $display("test power off done");
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(negedge i_clk);
      i_resetn = 1'b1;
      repeat (2) @(negedge i_clk);
      t_latch();
      t_layout();
      t_ref_div();
      t_fb_div();
      t_power();
      final_report();
   end

   // The run needs about 11000 cycles; a limit of 30000 leaves ample margin.
   initial
   begin
      #600000;
      n_mismatch++;
      final_report();
   end
endmodule
